//--- verif/ee2w_host.sv
`timescale 1ns/1ps
module ee2w_host (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sda_rel
);
   // ****************************************
   // Bus master model, stepping on mclk
   // ****************************************
   // Half period of 200 ns stays well clear of the slave's spike filter
   int glitch_at = -1;

   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   task automatic half();
      repeat (20) @(posedge mclk);
   endtask : half

   // Works from idle and as a repeated start from SCL low
   task automatic start();
      sda_rel <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_rel <= 1'b0;
      half();
      scl <= 1'b0;
      half();
   endtask : start

   task automatic stop();
      sda_rel <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_rel <= 1'b1;
      half();
   endtask : stop

   // A glitch pulls SCL low for 20 ns inside the high phase
   task automatic bit_x(input logic b, input logic gl, output logic r);
      sda_rel <= b;
      half();
      scl <= 1'b1;
      repeat (8) @(posedge mclk);
      if (gl) begin
         scl <= 1'b0;
         repeat (2) @(posedge mclk);
         scl <= 1'b1;
      end
      half();
      r = sda;
      scl <= 1'b0;
      // Keeps the next SDA change clear of the falling SCL edge
      repeat (4) @(posedge mclk);
   endtask : bit_x

   task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                       output logic ar);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], i == glitch_at, r);
         rx[i] = r;
      end
      bit_x(ab, 1'b0, ar);
   endtask : xfer
endmodule : ee2w_host

//--- verif/tb_ee2w_slave.sv
`timescale 1ns/1ps
module tb_ee2w_slave;
   localparam logic [3:0] DEV_ID = 4'h6; // Arbitrary identifier
   localparam int TWR = 2000;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic link_clk = 1'b0;
   logic [2:0] strap = 3'h0;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] rd_tab [4];
   int rd_idx = 0;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int busy_len = 0;
   logic [31:0] seed = 32'h34C7E634;
   logic [8:0] rxq [$];
   wire logic scl, sda_rel, sda_out, sda_oe_n, rx_valid, rx_first, rd_req, busy, stby, sda;
   wire logic [7:0] rx_data, word_addr;

   // Pull-up holds the wire high unless a party pulls it low
   assign sda = sda_rel & (sda_oe_n | sda_out);

   ee2w_slave #(.DEV_TYPE_ID(DEV_ID), .TWR_CYC(TWR)) dut (
      .mclk(mclk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_addr_bit_zero(strap[0]),
      .strap_addr_bit_one(strap[1]), .strap_addr_bit_two(strap[2]), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_first(rx_first), .word_addr(word_addr), .rd_req(rd_req),
      .rd_data(rd_data), .busy(busy), .stby(stby));

   ee2w_host host (.mclk(mclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

   always #5 mclk = ~mclk;

   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   // ****************************************
   // Monitors, read data supply and timeout
   // ****************************************
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1) rxq.push_back({rx_first, rx_data});
      if (rd_req === 1'b1 && rd_idx < 3) begin
         rd_idx <= rd_idx + 1;
         rd_data <= rd_tab[rd_idx + 1];
      end
      if (busy === 1'b1) busy_len <= busy_len + 1;
      if (cyc == 60000) begin
         fails++;
         report_and_stop();
      end
   end

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   function automatic logic [7:0] addr_b(input logic rd);
      return {DEV_ID, strap, rd};
   endfunction : addr_b

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [7:0] rx, wa, d1, d2;
      logic ack, b;
      int n;
      for (int i = 0; i < 4; i++) rd_tab[i] = 8'h00;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      wa = rnd();
      strap <= wa[2:0];
      repeat (30) @(posedge mclk);
      check(sda_oe_n, 1'b1);
      check(stby, 1'b1);
      check(busy, 1'b0);
      // A matching address clocked without a start must be ignored
      host.scl <= 1'b0;
      host.half();
      host.xfer(addr_b(1'b0), 1'b1, rx, ack);
      check(ack, 1'b1);
      host.stop();
      check(rxq.size(), 0);
      $display("test no_start done");

      host.start();
      check(stby, 1'b0);
      host.xfer(addr_b(1'b0), 1'b1, rx, ack);
      check(ack, 1'b0);
      check(sda_out, 1'b0);
      wa = rnd();
      d1 = rnd();
      d2 = rnd();
      host.xfer(wa, 1'b1, rx, ack);
      check(ack, 1'b0);
      host.glitch_at = 3;
      host.xfer(d1, 1'b1, rx, ack);
      host.glitch_at = -1;
      check(ack, 1'b0);
      host.xfer(d2, 1'b1, rx, ack);
      check(ack, 1'b0);
      busy_len = 0;
      host.stop();
      check(rxq.size(), 3);
      check(rxq[0], {1'b1, wa});
      check(rxq[1], {1'b0, d1});
      check(rxq[2], {1'b0, d2});
      check(word_addr, wa);
      check(busy, 1'b1);
      host.start();
      host.xfer(addr_b(1'b0), 1'b1, rx, ack);
      check(ack, 1'b1);
      n = 0;
      do begin
         host.start();
         host.xfer(addr_b(1'b0), 1'b1, rx, ack);
         n++;
      end while (ack !== 1'b0 && n < 12);
      check(ack, 1'b0);
      check(busy_len <= TWR && busy_len > TWR / 2, 1'b1);
      host.stop();
      check(stby, 1'b1);
      rxq.delete();
      $display("test write done");

      for (int k = 1; k < 8; k++) begin
         host.start();
         host.xfer(addr_b(1'b0) ^ (8'h01 << k), 1'b1, rx, ack);
         check(ack, 1'b1);
         host.stop();
      end
      check(rxq.size(), 0);
      $display("test refuse done");

      // Straps left floating read as zero
      strap <= 3'h0;
      for (int i = 0; i < 4; i++) rd_tab[i] = rnd();
      rd_data <= rd_tab[0];
      rd_idx = 0;
      wa = rnd();
      host.start();
      host.xfer(addr_b(1'b0), 1'b1, rx, ack);
      check(ack, 1'b0);
      host.xfer(wa, 1'b1, rx, ack);
      host.start();
      host.xfer(addr_b(1'b1), 1'b1, rx, ack);
      check(ack, 1'b0);
      for (int j = 0; j < 3; j++) begin
         host.xfer(8'hFF, j == 2, rx, ack);
         check(rx, rd_tab[j]);
      end
      host.half();
      check(sda_oe_n, 1'b1);
      host.stop();
      check(word_addr, wa);
      check(busy, 1'b0);
      check(stby, 1'b1);
      $display("test read done");

      // Abandon a read after two bits, then clock until SDA is free
      for (int i = 0; i < 4; i++) rd_tab[i] = 8'h00;
      rd_data <= 8'h00;
      rd_idx = 0;
      host.start();
      host.xfer(addr_b(1'b1), 1'b1, rx, ack);
      host.bit_x(1'b1, 1'b0, b);
      host.bit_x(1'b1, 1'b0, b);
      n = 0;
      do begin
         host.bit_x(1'b1, 1'b0, b);
         n++;
      end while (b !== 1'b1 && n < 9);
      check(n, 7);
      host.start();
      host.xfer(addr_b(1'b0), 1'b1, rx, ack);
      check(ack, 1'b0);
      host.stop();
      $display("test recovery done");
      report_and_stop();
   end
endmodule : tb_ee2w_slave

//--- verilog/ee2w_pkg.sv
package ee2w_pkg;
   // *****************************************************
   // Clock rates and link timing
   // *****************************************************
   localparam int MCLK_MHZ = 100;
   localparam int TWR_MS = 5;
   localparam int TWR_CYC_DEF = TWR_MS * 1000 * MCLK_MHZ;
   localparam int LINK_CLK_PS = 6000;
   localparam int SPIKE_NS = 50;
   localparam int FILT_CYC = (SPIKE_NS * 1000 + LINK_CLK_PS - 1) / LINK_CLK_PS;
   localparam int FILT_W = 4;
   localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);

   // *****************************************************
   // Byte framing and address byte layout
   // *****************************************************
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_PRE = 4'hF;
   localparam int TYPE_HI = 7;
   localparam int TYPE_LO = 4;
   localparam int STRAP_HI = 3;
   localparam int STRAP_LO = 1;
   localparam int RW_BIT = 0;
   localparam int WORD_ADDR_W = 8;
   localparam int PAGE_COUNT = 32;
   localparam int PAGE_BYTES = 8;
   localparam logic [7:0] BYTE_ONES = 8'hFF;

   typedef enum logic [1:0] {EW_IDLE, EW_RECV, EW_SEND} ee2w_state_e;
endpackage : ee2w_pkg

//--- verilog/ee2w_slave.sv
`timescale 1ns/1ps
module ee2w_slave import ee2w_pkg::*; #(
   parameter logic [3:0] DEV_TYPE_ID = 4'h5, // Arbitrary value
   parameter int TWR_CYC = TWR_CYC_DEF
) (
   input logic mclk,
   input logic rst_n,
   input logic link_clk,
   input logic scl_in,
   input logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input logic strap_addr_bit_zero,
   input logic strap_addr_bit_one,
   input logic strap_addr_bit_two,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_first,
   output logic [WORD_ADDR_W-1:0] word_addr,
   output logic rd_req,
   input logic [7:0] rd_data,
   output logic busy,
   output logic stby
);
   localparam int TW = $clog2(TWR_CYC + 1);

   // *****************************************************
   // Resets, one synchroniser per domain
   // *****************************************************
   logic mrst1, mrst_n, lrst1, lrst_n;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mrst1 <= 1'h0;
         mrst_n <= 1'h0;
      end else begin
         mrst1 <= 1'h1;
         mrst_n <= mrst1;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lrst1 <= 1'h0;
         lrst_n <= 1'h0;
      end else begin
         lrst1 <= 1'h1;
         lrst_n <= lrst1;
      end
   end

   // *****************************************************
   // Pin synchronisers and spike filter
   // *****************************************************
   logic [1:0] pin_s1, pin_s2, pin_f, pin_p;
   logic [2:0] strap_s1, strap_s;
   logic scl_f, sda_f, scl_p, sda_p;
   logic scl_rise, scl_fall, start_c, stop_c, bus_idle;

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         pin_s1 <= 2'h3;
         pin_s2 <= 2'h3;
         pin_p <= 2'h3;
         strap_s1 <= 3'h0;
         strap_s <= 3'h0;
      end else begin
         pin_s1 <= {sda_in, scl_in};
         pin_s2 <= pin_s1;
         pin_p <= pin_f;
         // Pads pull a floating strap down, so it arrives here as zero
         strap_s1 <= {strap_addr_bit_two, strap_addr_bit_one, strap_addr_bit_zero};
         strap_s <= strap_s1;
      end
   end

   // A level must hold for the whole spike time before it is believed
   for (genvar i = 0; i < 2; i++) begin : g_filt
      logic [FILT_W-1:0] cnt;
      logic f;
      always_ff @(posedge link_clk or negedge lrst_n) begin
         if (!lrst_n) begin
            cnt <= '0;
            f <= 1'h1;
         end else if (pin_s2[i] == f) begin
            cnt <= '0;
         end else if (cnt == FILT_LAST) begin
            cnt <= '0;
            f <= pin_s2[i];
         end else begin
            cnt <= cnt + 1'h1;
         end
      end
      assign pin_f[i] = f;
   end

   assign scl_f = pin_f[0];
   assign sda_f = pin_f[1];
   assign scl_p = pin_p[0];
   assign sda_p = pin_p[1];
   assign scl_rise = scl_f & ~scl_p;
   assign scl_fall = ~scl_f & scl_p;
   assign bus_idle = scl_f & sda_f;
   assign start_c = scl_f & scl_p & sda_p & ~sda_f;
   assign stop_c = scl_f & scl_p & ~sda_p & bus_idle;

   // *****************************************************
   // Link-side byte engine
   // *****************************************************
   ee2w_state_e state;
   logic [3:0] bitn;
   logic [7:0] shreg, txsh, rx_byte, load_byte;
   logic is_addr, rd_mode, wa_pend, wr_pend, nack, tx_ok;
   logic rx_first_l, rx_tgl, rd_tgl, wr_tgl, active;
   logic busy_l1, busy_s, ack_l1, ack_l2, ack_p;
   logic byte_end, slot_end, addr_ok, want_next, load_now;
   logic [7:0] tx_hold;
   logic tx_ack;

   assign byte_end = scl_fall && (bitn == BIT_LAST);
   assign slot_end = scl_fall && (bitn == BIT_ACK);
   assign addr_ok = (shreg[TYPE_HI:TYPE_LO] == DEV_TYPE_ID)
      && (shreg[STRAP_HI:STRAP_LO] == strap_s) && !busy_s;
   assign want_next = (state == EW_SEND) && scl_rise && (bitn == BIT_ACK) && !sda_f;
   assign load_now = slot_end && ((state == EW_SEND && !nack) || (state == EW_RECV && rd_mode));
   // Without a fresh answer the device sends all ones, which leaves SDA released
   assign load_byte = tx_ok ? tx_hold : BYTE_ONES;

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         busy_l1 <= 1'h0;
         busy_s <= 1'h0;
         ack_l1 <= 1'h0;
         ack_l2 <= 1'h0;
         sda_out <= 1'h0;
      end else begin
         busy_l1 <= busy;
         busy_s <= busy_l1;
         ack_l1 <= tx_ack;
         ack_l2 <= ack_l1;
         sda_out <= 1'h0;
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         state <= EW_IDLE;
         bitn <= BIT_PRE;
         shreg <= 8'h00;
         txsh <= BYTE_ONES;
         is_addr <= 1'h0;
         nack <= 1'h0;
         sda_oe_n <= 1'h1;
      end else if (start_c) begin
         state <= EW_RECV;
         bitn <= BIT_PRE;
         is_addr <= 1'h1;
         sda_oe_n <= 1'h1;
      end else if (stop_c) begin
         state <= EW_IDLE;
         sda_oe_n <= 1'h1;
      end else if (state != EW_IDLE) begin
         if (scl_rise && bitn < BIT_ACK && state == EW_RECV) begin
            shreg <= {shreg[6:0], sda_f};
         end
         if (scl_rise && bitn == BIT_ACK && state == EW_SEND) begin
            nack <= sda_f;
         end
         if (scl_fall) begin
            // The fall that follows a start opens no data clock
            if (bitn == BIT_ACK || bitn == BIT_PRE) begin
               bitn <= BIT_FIRST;
            end else begin
               bitn <= bitn + 4'h1;
            end
            if (bitn == BIT_LAST) begin
               if (state == EW_SEND) begin
                  sda_oe_n <= 1'h1;
               end else if (!is_addr || addr_ok) begin
                  sda_oe_n <= 1'h0;
               end else begin
                  state <= EW_IDLE;
               end
            end else if (bitn == BIT_ACK) begin
               is_addr <= 1'h0;
               if (state == EW_SEND && nack) begin
                  state <= EW_IDLE;
                  sda_oe_n <= 1'h1;
               end else if (load_now) begin
                  state <= EW_SEND;
                  sda_oe_n <= load_byte[7];
                  txsh <= {load_byte[6:0], 1'h1};
               end else begin
                  sda_oe_n <= 1'h1;
               end
            end else if (state == EW_SEND && bitn != BIT_PRE) begin
               sda_oe_n <= txsh[7];
               txsh <= {txsh[6:0], 1'h1};
            end
         end
      end
   end

   // *****************************************************
   // Link-side transaction flags and handshakes
   // *****************************************************
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         rd_mode <= 1'h0;
         wa_pend <= 1'h0;
         wr_pend <= 1'h0;
         tx_ok <= 1'h0;
         ack_p <= 1'h0;
         active <= 1'h0;
         rx_byte <= 8'h00;
         rx_first_l <= 1'h0;
         rx_tgl <= 1'h0;
         rd_tgl <= 1'h0;
         wr_tgl <= 1'h0;
      end else begin
         ack_p <= ack_l2;
         active <= (state != EW_IDLE);
         // A fresh answer wins over a load in the same cycle
         if (ack_l2 != ack_p) begin
            tx_ok <= 1'h1;
         end else if (load_now) begin
            tx_ok <= 1'h0;
         end
         if (start_c) begin
            rd_mode <= 1'h0;
            wr_pend <= 1'h0;
         end else if (stop_c) begin
            if (wr_pend) begin
               wr_tgl <= ~wr_tgl;
            end
            wr_pend <= 1'h0;
         end else if (state == EW_RECV && byte_end) begin
            if (is_addr) begin
               if (addr_ok) begin
                  rd_mode <= shreg[RW_BIT];
                  wa_pend <= ~shreg[RW_BIT];
                  if (shreg[RW_BIT]) begin
                     rd_tgl <= ~rd_tgl;
                  end
               end
            end else begin
               rx_byte <= shreg;
               rx_first_l <= wa_pend;
               rx_tgl <= ~rx_tgl;
               wa_pend <= 1'h0;
               if (!wa_pend) begin
                  wr_pend <= 1'h1;
               end
            end
         end else if (want_next) begin
            rd_tgl <= ~rd_tgl;
         end
      end
   end

   // *****************************************************
   // System side: bytes, read requests, write cycle
   // *****************************************************
   logic rx_m1, rx_m2, rx_mp, rd_m1, rd_m2, rd_mp, wr_m1, wr_m2, wr_mp, act_m1, act_m2;
   logic [TW-1:0] wr_cnt;

   always_ff @(posedge mclk or negedge mrst_n) begin
      if (!mrst_n) begin
         {rx_m1, rx_m2, rx_mp, rd_m1, rd_m2, rd_mp} <= 6'h00;
         {wr_m1, wr_m2, wr_mp, act_m1, act_m2} <= 5'h00;
      end else begin
         {rx_m1, rx_m2, rx_mp} <= {rx_tgl, rx_m1, rx_m2};
         {rd_m1, rd_m2, rd_mp} <= {rd_tgl, rd_m1, rd_m2};
         {wr_m1, wr_m2, wr_mp} <= {wr_tgl, wr_m1, wr_m2};
         {act_m1, act_m2} <= {active, act_m1};
      end
   end

   // Link bytes stay put for a whole byte time, far longer than the crossing
   always_ff @(posedge mclk or negedge mrst_n) begin
      if (!mrst_n) begin
         rx_valid <= 1'h0;
         rx_data <= 8'h00;
         rx_first <= 1'h0;
         word_addr <= 8'h00;
      end else begin
         rx_valid <= (rx_m2 != rx_mp);
         if (rx_m2 != rx_mp) begin
            rx_data <= rx_byte;
            rx_first <= rx_first_l;
            if (rx_first_l) begin
               word_addr <= rx_byte;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge mrst_n) begin
      if (!mrst_n) begin
         rd_req <= 1'h0;
         tx_hold <= BYTE_ONES;
         tx_ack <= 1'h0;
      end else begin
         rd_req <= (rd_m2 != rd_mp);
         if (rd_req) begin
            tx_hold <= rd_data;
            tx_ack <= ~tx_ack;
         end
      end
   end

   always_ff @(posedge mclk or negedge mrst_n) begin
      if (!mrst_n) begin
         busy <= 1'h0;
         wr_cnt <= '0;
         stby <= 1'h1;
      end else begin
         if (wr_m2 != wr_mp) begin
            busy <= 1'h1;
            wr_cnt <= TW'(TWR_CYC - 1);
         end else if (busy) begin
            if (wr_cnt == '0) begin
               busy <= 1'h0;
            end else begin
               wr_cnt <= wr_cnt - 1'h1;
            end
         end
         stby <= !act_m2 && !busy && (wr_m2 == wr_mp);
      end
   end

   // *****************************************************
   // Checks
   // *****************************************************
   property p_sample_rise;
      @(posedge link_clk) disable iff (!lrst_n)
      (state == EW_RECV && scl_rise && bitn < BIT_ACK) |=> shreg[0] == $past(sda_f);
   endproperty
   a_sample_rise: assert property (p_sample_rise) else $error("bit not sampled");

   property p_drive_fall;
      @(posedge link_clk) disable iff (!lrst_n)
      $changed(sda_oe_n) |-> $past(scl_fall || start_c || stop_c);
   endproperty
   a_drive_fall: assert property (p_drive_fall) else $error("SDA moved off edge");

   property p_start;
      @(posedge link_clk) disable iff (!lrst_n)
      start_c |=> state == EW_RECV && bitn == BIT_PRE && sda_oe_n;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_stop;
      @(posedge link_clk) disable iff (!lrst_n)
      stop_c |=> state == EW_IDLE && sda_oe_n;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   property p_addr_ack;
      @(posedge link_clk) disable iff (!lrst_n)
      (state == EW_RECV && is_addr && byte_end && addr_ok) |=> !sda_oe_n [*2];
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

   property p_type_miss;
      @(posedge link_clk) disable iff (!lrst_n)
      (state == EW_RECV && is_addr && byte_end && shreg[TYPE_HI:TYPE_LO] != DEV_TYPE_ID)
         |=> state == EW_IDLE && sda_oe_n;
   endproperty
   a_type_miss: assert property (p_type_miss) else $error("foreign type acked");

   property p_busy_nack;
      @(posedge link_clk) disable iff (!lrst_n)
      (state == EW_RECV && is_addr && byte_end && busy_s && !start_c && !stop_c)
         |=> sda_oe_n;
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");

   property p_ack_release;
      @(posedge link_clk) disable iff (!lrst_n)
      (state == EW_RECV && !rd_mode && slot_end) |=> sda_oe_n;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack held");

   property p_nack_end;
      @(posedge link_clk) disable iff (!lrst_n)
      (state == EW_SEND && slot_end && nack) |=> state == EW_IDLE && sda_oe_n;
   endproperty
   a_nack_end: assert property (p_nack_end) else $error("sent after nack");

   property p_busy_hold;
      @(posedge mclk) disable iff (!mrst_n)
      (wr_m2 != wr_mp) |=> busy [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");

   property p_stby_busy;
      @(posedge mclk) disable iff (!mrst_n)
      busy |=> !stby;
   endproperty
   a_stby_busy: assert property (p_stby_busy) else $error("standby during write");
endmodule : ee2w_slave
